// *** obs_consts.vh ***
// timing and reset constants for the break-before-make channel sequencer
`ifndef OBS_CONSTS_VH
`define OBS_CONSTS_VH

// ----------------------------------------
// clock
// ----------------------------------------
`define OBS_CLK_MHZ 25

// ----------------------------------------
// waits in microseconds
// ----------------------------------------
`define OBS_DIS_TO_ADDR_US 10
`define OBS_ADDR_TO_EN_US 40
`define OBS_EN_SETTLE_US 10

// ----------------------------------------
// waits in cycles (all exact multiples)
// ----------------------------------------
`define OBS_DIS_TO_ADDR_CYC (`OBS_DIS_TO_ADDR_US * `OBS_CLK_MHZ)
`define OBS_ADDR_TO_EN_CYC (`OBS_ADDR_TO_EN_US * `OBS_CLK_MHZ)
`define OBS_EN_SETTLE_CYC (`OBS_EN_SETTLE_US * `OBS_CLK_MHZ)

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define OBS_ADDR_W 5
`define OBS_CNT_W 11
`define OBS_ADDR_RST 5'h00

`endif

// *** obs_wait_timer.v ***
// down-counting wait timer with load strobe and done flag
module obs_wait_timer #(
   parameter CNT_W = 11
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_b_i,
   // control
   input wire load_i,
   input wire [CNT_W-1:0] load_val_i,
   // status
   output wire done_o
);

   reg [CNT_W-1:0] cnt_reg;
   reg [CNT_W-1:0] cnt_next;

   always @* begin
      cnt_next = cnt_reg;
      if (load_i) begin
         cnt_next = load_val_i;
      end else if (cnt_reg != {CNT_W{1'b0}}) begin
         cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= {CNT_W{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // done when count reaches 1 so the loaded value equals the wait length
   assign done_o = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule // obs_wait_timer

// *** obs_sequencer.v ***
// host sequencer driving channel address and enable with break-before-make
// ----------------------------------------
// Function
// - drop enable before changing address
// - wait 10 us after disable
// - then drive the new channel address
// - wait 40 us more before enabling
// - raise enable; addressed channel turns on
// - wait 10 us after enable
// - power-on: address valid, enable last
// ----------------------------------------
`include "obs_consts.vh"

module obs_sequencer #(
   parameter ADDR_W = `OBS_ADDR_W,
   parameter CNT_W = `OBS_CNT_W,
   parameter [CNT_W-1:0] DIS_CYC = `OBS_DIS_TO_ADDR_CYC,
   parameter [CNT_W-1:0] ADDR_CYC = `OBS_ADDR_TO_EN_CYC,
   parameter [CNT_W-1:0] EN_CYC = `OBS_EN_SETTLE_CYC
) (
   // clock and reset
   input wire core_clk_i,
   input wire rst_b_i,
   // channel request
   input wire req_i,
   input wire [ADDR_W-1:0] req_chan_i,
   input wire req_off_i,
   output reg busy_o,
   // device pins
   output reg [ADDR_W-1:0] channel_address_o,
   output reg channel_enable_o
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DIS = 3'h1;
   localparam [2:0] ST_ADDR = 3'h2;
   localparam [2:0] ST_EN = 3'h3;
   localparam [2:0] ST_SETTLE = 3'h4;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [ADDR_W-1:0] tgt_reg;
   reg [ADDR_W-1:0] tgt_next;
   reg off_reg;
   reg off_next;
   reg [ADDR_W-1:0] addr_next;
   reg en_next;
   reg busy_next;
   reg load;
   reg [CNT_W-1:0] load_val;
   wire tmr_done;

   // ----------------------------------------
   // wait timer
   // ----------------------------------------
   obs_wait_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .load_i(load),
      .load_val_i(load_val),
      .done_o(tmr_done)
   );

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      tgt_next = tgt_reg;
      off_next = off_reg;
      addr_next = channel_address_o;
      en_next = channel_enable_o;
      busy_next = busy_o;
      load = 1'b0;
      load_val = DIS_CYC;
      case (state_reg)
         ST_IDLE: begin
            if (req_i) begin
               tgt_next = req_chan_i;
               off_next = req_off_i;
               en_next = 1'b0;
               busy_next = 1'b1;
               load = 1'b1;
               load_val = DIS_CYC;
               state_next = ST_DIS;
            end
         end
         ST_DIS: begin
            if (tmr_done) begin
               addr_next = tgt_reg;
               load = 1'b1;
               load_val = ADDR_CYC;
               state_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (tmr_done) begin
               if (off_reg) begin
                  busy_next = 1'b0;
                  state_next = ST_IDLE;
               end else begin
                  en_next = 1'b1;
                  load = 1'b1;
                  load_val = EN_CYC;
                  state_next = ST_SETTLE;
               end
            end
         end
         ST_SETTLE: begin
            if (tmr_done) begin
               busy_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         default: begin
            en_next = 1'b0;
            busy_next = 1'b0;
            state_next = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_IDLE;
         tgt_reg <= `OBS_ADDR_RST;
         off_reg <= 1'b0;
         channel_address_o <= `OBS_ADDR_RST;
         channel_enable_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         tgt_reg <= tgt_next;
         off_reg <= off_next;
         channel_address_o <= addr_next;
         channel_enable_o <= en_next;
         busy_o <= busy_next;
      end
   end

endmodule // obs_sequencer

// *** obs_dev_model.sv ***
// behavioural model of the 1-of-32 driver with enable
module obs_dev_model (
   // device pins
   input wire logic [4:0] channel_address_i,
   input wire logic channel_enable_i,
   // driver channels
   output logic [31:0] driver_output_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] lag = 5'h00;
   // the old channel lingers briefly after an address change
   always @(channel_address_i) lag <= #100 channel_address_i;
   assign driver_output_o = channel_enable_i ?
      (32'h1 << channel_address_i) | (32'h1 << lag) : 32'h0;
endmodule // obs_dev_model

// *** obs_sequencer_asserts.sv ***
// port checks for the channel sequencer
module obs_seq_asserts #(
   parameter int DIS_CYC = 3
) (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire req_i,
   input wire [4:0] req_chan_i,
   input wire req_off_i,
   input wire busy_o,
   input wire [4:0] channel_address_o,
   input wire channel_enable_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire acc = req_i && !busy_o;
   a_accept_drops_en: assert property (acc |=> busy_o && !channel_enable_o)
      else $error("enable not dropped on accept");
   a_addr_only_off: assert property (!$stable(channel_address_o) |->
      !channel_enable_o && !$past(channel_enable_o)) else $error("address moved while on");
   a_addr_hold: assert property (acc |=> $stable(channel_address_o) [*2])
      else $error("address moved too early");
   a_addr_set: assert property (acc && !req_off_i |-> ##DIS_CYC ##1
      channel_address_o == $past(req_chan_i, DIS_CYC + 1)) else $error("wrong address");
   a_en_wait: assert property (acc && !req_off_i |->
      ##1 !channel_enable_o [*7] ##1 channel_enable_o) else $error("enable timing");
   a_busy_end: assert property (acc && !req_off_i |->
      ##1 busy_o [*5] ##1 busy_o [*5] ##1 !busy_o) else $error("busy timing");
   a_off_idle: assert property (acc && req_off_i |->
      ##1 (busy_o && !channel_enable_o) [*7] ##1 !busy_o && !channel_enable_o)
      else $error("off sequence");
   a_en_rise_busy: assert property ($rose(channel_enable_o) |->
      busy_o && $stable(channel_address_o)) else $error("enable outside sequence");
endmodule // obs_seq_asserts
bind obs_sequencer obs_seq_asserts #(.DIS_CYC(DIS_CYC)) u_obs_seq_asserts (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .req_chan_i(req_chan_i),
   .req_off_i(req_off_i), .busy_o(busy_o), .channel_address_o(channel_address_o),
   .channel_enable_o(channel_enable_o));

// *** obs_sequencer_bench.sv ***
// self-checking bench for the channel sequencer
module obs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, off = 1'b0, busy, en;
   logic [4:0] chan = 5'h00, addr;
   logic [31:0] drv;
   int failures = 0, n_compared = 0, cyc = 0;
   always #20 clk = ~clk;
   obs_sequencer #(.DIS_CYC(11'h003), .ADDR_CYC(11'h004), .EN_CYC(11'h003)) u_obs_sequencer (
      .core_clk_i(clk), .rst_b_i(rst_b), .req_i(req), .req_chan_i(chan), .req_off_i(off),
      .busy_o(busy), .channel_address_o(addr), .channel_enable_o(en));
   obs_dev_model u_obs_dev_model (.channel_address_i(addr), .channel_enable_i(en),
      .driver_output_o(drv));
   task summarize;
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 500) begin
         failures++;
         summarize();
      end
   end
   // one request; bump tries a refused request mid-sequence
   task automatic seq(input logic [4:0] ch, input logic o, input logic bump);
      logic [4:0] old;
      old = addr;
      @(negedge clk);
      req = 1'b1; chan = ch; off = o;
      for (int n = 1; n <= 11; n++) begin
         @(negedge clk);
         req = bump && n == 2;
         if (n == 2) chan = ~ch;
         chk("busy", busy, n < (o ? 8 : 11));
         chk("en", en, !o && n >= 8);
         if (n < 4) chk("addr_hold", addr, old);
         else if (!o) chk("addr", addr, ch);
      end
      chk("out", drv, o ? 32'h0 : 32'h1 << ch);
   endtask
   task t_reset;
      chk("rst", {busy, en, addr}, 7'h00);
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
   endtask
   task t_switch;
      seq(5'h05, 1'b0, 1'b0);
      seq(5'h1F, 1'b0, 1'b1);
      seq(5'h00, 1'b0, 1'b0);
   endtask
   task t_off;
      seq(5'h0A, 1'b1, 1'b0);
   endtask
   initial begin
      #1 t_reset();
      t_switch();
      t_off();
      summarize();
   end
endmodule // obs_sequencer_bench
